// File: ppmp_pkg.sv
// Package: constants for the parallel master pin block
// Functional notes
// - Ports mode at reset; master when selection=10
// - Control outputs change once per interface clock
// - Control outputs default high
// - Low four: push-pull, open-drain or tristatable
// - Upper two unavailable in tristatable mode
// - Ready sampling sync or async delayed
// - Address value written drives pins immediately
// - Address increments on waveform request
// - Address floats when alternate and enables clear
// - Config bit 2 selects state debug outputs
// - State debug shows current waveform state
// - Low data byte on first port always
// - High byte port when any word-width bit
// - First byte low lines, second high lines
// - Internal clock 30 or 48 MHz, optional output; the code makes 7.5 or 11.875 MHz
// - Reset: internal, 48 MHz, normal, output off
// - Config bit 7 selects clock source
// - Config bit 6 selects internal frequency
// - Config bit 5 enables clock output
// - Config bit 4 inverts clock polarity
package ppmp_pkg;
    localparam logic [2:0] PPMP_ADDR_IFCFG = 3'h0;
    localparam logic [2:0] PPMP_ADDR_CTLCFG = 3'h1;
    localparam logic [2:0] PPMP_ADDR_ADRH = 3'h2;
    localparam logic [2:0] PPMP_ADDR_ADRL = 3'h3;
    localparam logic [2:0] PPMP_ADDR_PORTCFG = 3'h4;
    localparam logic [2:0] PPMP_ADDR_WAVE = 3'h5;
    localparam logic [2:0] PPMP_ADDR_STATUS = 3'h6;
    localparam logic [2:0] PPMP_ADDR_DATA = 3'h7;
    localparam int PPMP_IFCFG_SRC_BIT = 7;
    localparam int PPMP_IFCFG_FREQ_BIT = 6;
    localparam int PPMP_IFCFG_OE_BIT = 5;
    localparam int PPMP_IFCFG_INV_BIT = 4;
    localparam int PPMP_IFCFG_STATE_DEBUG_OUTPUTS_BIT = 2;
    localparam int PPMP_CTLCFG_TRI_BIT = 7;
    localparam logic [1:0] PPMP_SEL_MASTER = 2'h2;
    localparam logic [7:0] PPMP_IFCFG_RESET = 8'hc0;
    localparam logic [7:0] PPMP_CTLCFG_RESET = 8'h00;
    localparam logic [5:0] PPMP_CTL_DEFAULT = 6'h3f;
    localparam int PPMP_CLK_MHZ = 40;
    localparam int PPMP_INT_FAST_MHZ = 48;
    localparam int PPMP_INT_SLOW_MHZ = 30;
    // Async ready delay, nanoseconds
    localparam int PPMP_ASYNC_DLY_NS = 24;
    localparam int PPMP_ASYNC_DLY_CYC = (PPMP_ASYNC_DLY_NS * PPMP_CLK_MHZ) / 1000 < 1 ? 1 :
        (PPMP_ASYNC_DLY_NS * PPMP_CLK_MHZ) / 1000;
    // Internal interface clock as phase accumulator step over 40 MHz
    localparam logic [7:0] PPMP_STEP_FAST = 8'(PPMP_INT_FAST_MHZ * 128 / PPMP_CLK_MHZ / 2);
    localparam logic [7:0] PPMP_STEP_SLOW = 8'(PPMP_INT_SLOW_MHZ * 128 / PPMP_CLK_MHZ / 2);
endpackage

// File: ppmp_pins.sv
// Module: pin-level control of the parallel master interface
//
// Our own choices: the placing of the registers and the address-and-strobe port.
`timescale 1ns/1ps
module ppmp_pins
    import ppmp_pkg::*;
#(
    parameter int READY_W = 6
) (
    input wire logic clk_i,                     // System clock, 40 MHz
    input wire logic resetn_i,                  // Async reset, active low
    input wire logic [2:0] reg_addr_i,          // Register address
    input wire logic [7:0] reg_wdata_i,         // Register write data
    input wire logic reg_wr_i,                  // Write strobe
    input wire logic reg_rd_i,                  // Read strobe
    output logic [7:0] reg_rdata_o,             // Read data, next cycle
    input wire logic [3:0] word_width_select_i, // Endpoint word-width bits
    input wire logic [2:0] wave_state_i,        // Current waveform state
    input wire logic [5:0] wave_ctl_i,          // Waveform control levels
    input wire logic [3:0] wave_ctl_oe_i,       // Waveform enables, tristate mode
    input wire logic wave_addr_inc_i,           // Address increment request
    input wire logic [15:0] wave_data_i,        // Byte pair to drive
    input wire logic wave_data_oe_i,            // Drive data bus
    input wire logic [READY_W-1:0] ready_i,     // Ready pins
    output logic [READY_W-1:0] ready_o,         // Sampled ready levels
    output logic interface_clock_tick_o,                  // Interface clock rise enable
    input wire logic interface_clock_i,         // Interface clock pin in
    output logic interface_clock_o,             // Interface clock pin out
    output logic interface_clock_oe_o,          // Interface clock pin enable
    output logic [5:0] control_outputs_o,       // Control output levels
    output logic [5:0] control_outputs_oe_o,    // Control output enables
    output logic [8:0] address_outputs_o,       // Address lines
    output logic [8:0] address_outputs_oe_o,    // Address enables
    output logic [2:0] state_debug_outputs_o,   // State debug pins
    output logic [2:0] state_debug_oe_o,        // State debug enables
    input wire logic [15:0] fifo_data_bus_i,    // Data pins in
    output logic [15:0] fifo_data_bus_o,        // Data pins out
    output logic [15:0] fifo_data_bus_oe_o,     // Data pin enables
    output logic master_mode_o,                 // Pins in master mode
    output logic high_byte_port_o               // High byte port assigned
);
    typedef struct packed {
        logic [7:0] ifcfg;
        logic [7:0] ctlcfg;
        logic [8:0] addr;
        logic [7:0] portcfg;
        logic ready_sampling_mode;
        logic [7:0] rdata;
        logic [1:0] clk_sync;
        logic clk_last;
        logic [7:0] phase;
        logic [5:0] ctl;
        logic [3:0] ctl_oe;
        logic [15:0] data;
        logic data_oe;
        logic [2:0] dbg;
        logic [READY_W-1:0] rdy_s1;
        logic [READY_W-1:0] rdy_s2;
        logic [READY_W-1:0] rdy_sync;
        logic [READY_W-1:0] rdy_async;
        logic [PPMP_ASYNC_DLY_CYC*READY_W-1:0] rdy_dly;
        logic [15:0] din_s1;
        logic [15:0] din;
    } ppmp_state_s;

    ppmp_state_s st_reg;
    ppmp_state_s st_next;
    logic master;
    logic tri_mode;
    logic ext_src;
    logic interface_clock_lvl;
    logic tick;

    assign master = st_reg.ifcfg[1:0] == PPMP_SEL_MASTER;
    assign tri_mode = st_reg.ctlcfg[PPMP_CTLCFG_TRI_BIT];
    assign ext_src = ~st_reg.ifcfg[PPMP_IFCFG_SRC_BIT];
    // External edge seen after inversion; internal uses accumulator MSB
    assign interface_clock_lvl = ext_src ? (st_reg.clk_sync[1] ^ st_reg.ifcfg[PPMP_IFCFG_INV_BIT])
                               : st_reg.phase[7];
    assign tick = interface_clock_lvl & ~st_reg.clk_last;

    always_comb begin
        st_next = st_reg;
        st_next.rdata = 8'h00;
        st_next.clk_sync = {st_reg.clk_sync[0], interface_clock_i};
        st_next.clk_last = interface_clock_lvl;
        // 40 MHz cannot make 48 MHz; the accumulator averages a quarter of the set rate, 11.875 or 7.5 MHz
        st_next.phase = st_reg.phase + (st_reg.ifcfg[PPMP_IFCFG_FREQ_BIT] ?
                        PPMP_STEP_FAST : PPMP_STEP_SLOW);
        st_next.rdy_s1 = ready_i;
        st_next.rdy_s2 = st_reg.rdy_s1;
        // Shift by one ready word; the newest word enters at the bottom
        st_next.rdy_dly = st_reg.rdy_dly << READY_W;
        st_next.rdy_dly[READY_W-1:0] = st_reg.rdy_s2;
        st_next.rdy_async = st_reg.rdy_dly[PPMP_ASYNC_DLY_CYC*READY_W-1 -: READY_W];
        // Data pins are asynchronous; two flops before the read mux
        st_next.din_s1 = fifo_data_bus_i;
        st_next.din = st_reg.din_s1;
        if (tick) begin
            st_next.rdy_sync = st_reg.rdy_s2;
            // Levels move only on interface clock edges
            st_next.ctl = wave_ctl_i;
            st_next.ctl_oe = wave_ctl_oe_i;
            st_next.dbg = wave_state_i;
            st_next.data = wave_data_i;
            st_next.data_oe = wave_data_oe_i;
            if (wave_addr_inc_i) begin
                st_next.addr = st_reg.addr + 9'h001;
            end
        end
        if (reg_wr_i) begin
            case (reg_addr_i)
                PPMP_ADDR_IFCFG: st_next.ifcfg = reg_wdata_i;
                PPMP_ADDR_CTLCFG: st_next.ctlcfg = reg_wdata_i;
                PPMP_ADDR_ADRH: st_next.addr[8] = reg_wdata_i[0];
                PPMP_ADDR_ADRL: st_next.addr[7:0] = reg_wdata_i;
                PPMP_ADDR_PORTCFG: st_next.portcfg = reg_wdata_i;
                PPMP_ADDR_WAVE: st_next.ready_sampling_mode = reg_wdata_i[0];
                default: st_next.rdata = 8'h00;
            endcase
        end
        if (reg_rd_i) begin
            case (reg_addr_i)
                PPMP_ADDR_IFCFG: st_next.rdata = st_reg.ifcfg;
                PPMP_ADDR_CTLCFG: st_next.rdata = st_reg.ctlcfg;
                PPMP_ADDR_ADRH: st_next.rdata = {7'h00, st_reg.addr[8]};
                PPMP_ADDR_ADRL: st_next.rdata = st_reg.addr[7:0];
                PPMP_ADDR_PORTCFG: st_next.rdata = st_reg.portcfg;
                PPMP_ADDR_WAVE: st_next.rdata = {7'h00, st_reg.ready_sampling_mode};
                PPMP_ADDR_STATUS: st_next.rdata = {master, high_byte_port_o, 3'h0, st_reg.dbg};
                PPMP_ADDR_DATA: st_next.rdata = st_reg.din[7:0];
                default: st_next.rdata = 8'h00;
            endcase
        end
    end

    always_ff @(posedge clk_i or negedge resetn_i) begin
        if (!resetn_i) begin
            st_reg <= '0;
            st_reg.ifcfg <= PPMP_IFCFG_RESET;
            st_reg.ctlcfg <= PPMP_CTLCFG_RESET;
            st_reg.ctl <= PPMP_CTL_DEFAULT;
        end else begin
            st_reg <= st_next;
        end
    end

    assign reg_rdata_o = st_reg.rdata;
    assign master_mode_o = master;
    assign interface_clock_tick_o = tick;
    assign ready_o = st_reg.ready_sampling_mode ? st_reg.rdy_sync : st_reg.rdy_async;
    // Pin is driven only for internal source with output enabled
    assign interface_clock_oe_o = ~ext_src & st_reg.ifcfg[PPMP_IFCFG_OE_BIT];
    assign interface_clock_o = st_reg.phase[7] ^ st_reg.ifcfg[PPMP_IFCFG_INV_BIT];

    genvar gi;
    generate
        for (gi = 0; gi < 6; gi++) begin : g_ctl
            logic od;
            assign od = st_reg.ctlcfg[gi];
            if (gi < 4) begin : g_low
                // Tristate mode overrides the per-output mode bit
                assign control_outputs_o[gi] = st_reg.ctl[gi];
                assign control_outputs_oe_o[gi] = !master ? 1'b0 :
                    tri_mode ? st_reg.ctl_oe[gi] : (od ? ~st_reg.ctl[gi] : 1'b1);
            end else begin : g_high
                assign control_outputs_o[gi] = st_reg.ctl[gi];
                assign control_outputs_oe_o[gi] = !master || tri_mode ? 1'b0 :
                    (od ? ~st_reg.ctl[gi] : 1'b1);
            end
        end
    endgenerate

    assign address_outputs_o = st_reg.addr;
    // Bit 0 alternate, bit 1 output enable; both clear floats the lines
    assign address_outputs_oe_o = {9{master & (st_reg.portcfg[0] | st_reg.portcfg[1])}};
    assign state_debug_outputs_o = st_reg.dbg;
    assign state_debug_oe_o = {3{st_reg.ifcfg[PPMP_IFCFG_STATE_DEBUG_OUTPUTS_BIT]}};
    assign high_byte_port_o = master & (|word_width_select_i);
    assign fifo_data_bus_o = st_reg.data;
    assign fifo_data_bus_oe_o = {{8{high_byte_port_o & st_reg.data_oe}},
                                 {8{master & st_reg.data_oe}}};
endmodule

// File: ppmp_checker.sv
// Checker: port properties of the parallel master pin block
`timescale 1ns/1ps
module ppmp_checker
    import ppmp_pkg::*;
#(
    parameter int READY_W = 6
) (
    input wire logic clk_i, // Clock
    input wire logic resetn_i, // Reset, active low
    input wire logic [2:0] reg_addr_i, // Address
    input wire logic [7:0] reg_wdata_i, // Write data
    input wire logic reg_wr_i, // Write strobe
    input wire logic [READY_W-1:0] ready_i, // Ready pins
    input wire logic [READY_W-1:0] ready_o, // Sampled ready
    input wire logic interface_clock_tick_o, // Interface tick
    input wire logic [5:0] control_outputs_o, // Control levels
    input wire logic [5:0] control_outputs_oe_o, // Control enables
    input wire logic [8:0] address_outputs_oe_o, // Address enables
    input wire logic interface_clock_oe_o, // Clock pin enable
    input wire logic master_mode_o // Master mode
);
    logic [7:0] ifc_reg;
    logic [7:0] ctc_reg;
    logic [1:0] pcf_reg;
    logic sas_reg;
    // Shadow of bus writes, so checks need no internal probes
    always_ff @(posedge clk_i or negedge resetn_i) begin
        if (!resetn_i) begin
            {ifc_reg, ctc_reg, pcf_reg, sas_reg} <= {PPMP_IFCFG_RESET, PPMP_CTLCFG_RESET, 3'h0};
        end else if (reg_wr_i) begin
            if (reg_addr_i == PPMP_ADDR_IFCFG) ifc_reg <= reg_wdata_i;
            if (reg_addr_i == PPMP_ADDR_CTLCFG) ctc_reg <= reg_wdata_i;
            if (reg_addr_i == PPMP_ADDR_PORTCFG) pcf_reg <= reg_wdata_i[1:0];
            if (reg_addr_i == PPMP_ADDR_WAVE) sas_reg <= reg_wdata_i[0];
        end
    end
    default clocking @(posedge clk_i); endclocking
    default disable iff (!resetn_i);
    mode_entry_a: assert property (reg_wr_i && reg_addr_i == PPMP_ADDR_IFCFG
        |=> master_mode_o == (($past(reg_wdata_i) & 8'h03) == 8'h02))
        else $error("master mode does not follow selection field");
    ctl_pace_a: assert property ($changed(control_outputs_o)
        |-> $past(interface_clock_tick_o)) else $error("control output moved off a clock tick");
    ctl_default_a: assert property (!$past(resetn_i)
        |-> control_outputs_o == PPMP_CTL_DEFAULT) else $error("control outputs not high");
    upper_off_a: assert property ($stable(ctc_reg) && ctc_reg[7]
        |-> control_outputs_oe_o[5:4] == 2'h0) else $error("upper controls driven");
    od_enable_a: assert property (master_mode_o && $stable(master_mode_o)
        && $stable(ctc_reg) && !ctc_reg[7]
        |-> control_outputs_oe_o == (~ctc_reg[5:0] | ~control_outputs_o))
        else $error("control enable wrong for drive mode");
    ready_async_a: assert property ((!sas_reg && $stable(ready_i))[*6]
        |-> ready_o == ready_i) else $error("async ready not settled");
    clk_out_a: assert property (interface_clock_oe_o == (ifc_reg[7] && ifc_reg[5]))
        else $error("clock pin enable wrong");
    addr_float_a: assert property (pcf_reg == 2'h0
        |-> address_outputs_oe_o == 9'h0) else $error("address lines not floating");
endmodule

// File: ppmp_far.sv
// Partner: peripheral with free-running clock and echoed ready lines
`timescale 1ns/1ps
module ppmp_far (
    input wire logic [5:0] ctl_i, // Control levels from block
    input wire logic slow_i, // Answer late
    output logic ext_clk_o = 1'b0, // Free-running interface clock
    output logic [5:0] ready_o = 6'h3f // Ready levels
);
    always #100 ext_clk_o = ~ext_clk_o;
    // Transport delay so slow replies lag several system clocks
    always @(ctl_i) ready_o <= #(slow_i ? 300 : 30) ctl_i;
endmodule

// File: tb_ppmp_pins.sv
// Testbench: pin configuration of the parallel master block
`timescale 1ns/1ps
module tb_ppmp_pins;
    import ppmp_pkg::*;
    logic clk = 1'b0, resetn = 1'b0, wr = 1'b0, rd = 1'b0, inc = 1'b0, doe = 1'b0, slow = 1'b0;
    logic [2:0] adr = 3'h0, wst = 3'h0, sdo, sdoe;
    logic [7:0] wd = 8'h00, rdata;
    logic [3:0] wws = 4'h0, coe = 4'h0;
    logic [5:0] wctl = 6'h3f, rdy, rdo, ctl, ctloe;
    logic [15:0] wdat = 16'h0, fdi = 16'h0, fdo, fdoe;
    logic [8:0] ao, aoe;
    logic tick, ick, icko, ickoe, mm, hb;
    int err_total = 0;
    int num_checks = 0;
    always #12.5 clk = ~clk;
    ppmp_pins uut (.clk_i(clk), .resetn_i(resetn), .reg_addr_i(adr), .reg_wdata_i(wd),
        .reg_wr_i(wr), .reg_rd_i(rd), .reg_rdata_o(rdata), .word_width_select_i(wws),
        .wave_state_i(wst), .wave_ctl_i(wctl), .wave_ctl_oe_i(coe), .wave_addr_inc_i(inc),
        .wave_data_i(wdat), .wave_data_oe_i(doe), .ready_i(rdy), .ready_o(rdo),
        .interface_clock_tick_o(tick), .interface_clock_i(ick), .interface_clock_o(icko),
        .interface_clock_oe_o(ickoe), .control_outputs_o(ctl), .control_outputs_oe_o(ctloe),
        .address_outputs_o(ao), .address_outputs_oe_o(aoe), .state_debug_outputs_o(sdo),
        .state_debug_oe_o(sdoe), .fifo_data_bus_i(fdi), .fifo_data_bus_o(fdo),
        .fifo_data_bus_oe_o(fdoe), .master_mode_o(mm), .high_byte_port_o(hb));
    ppmp_far far_u (.ctl_i(ctl), .slow_i(slow), .ext_clk_o(ick), .ready_o(rdy));
    task automatic chk(input logic [15:0] got, input logic [15:0] exp);
        num_checks++;
        if (got !== exp) begin
            err_total++;
            $display("mismatch at %0t: got %h exp %h", $time, got, exp);
        end
    endtask
    task automatic wreg(input logic [2:0] a, input logic [7:0] d);
        adr <= a;
        wd <= d;
        wr <= 1'b1;
        @(posedge clk);
        wr <= 1'b0;
        // Idle edge, so a following write never re-raises the strobe in one step
        @(posedge clk);
    endtask
    task automatic ticks(input int n);
        repeat (n) begin
            @(posedge clk);
            while (tick !== 1'b1) @(posedge clk);
        end
    endtask
    task automatic complete_run();
        $display("checks %0d mismatches %0d", num_checks, err_total);
        if (err_total == 0 && num_checks > 0) begin
            $display("== PASSED ==");
        end else begin
            $display("== FAILED ==");
        end
        $finish;
    endtask
    initial begin
        #200_000;
        err_total++;
        complete_run();
    end
    initial begin
        logic [7:0] v;
        logic [8:0] a;
        int n;
        logic p;
        void'($urandom(73436));
        repeat (12) @(posedge clk);
        resetn <= 1'b1;
        @(posedge clk);
        adr <= PPMP_ADDR_IFCFG;
        rd <= 1'b1;
        #1 chk(ctl, PPMP_CTL_DEFAULT);
        chk({mm, ickoe, sdoe}, 5'h0);
        @(posedge clk);
        rd <= 1'b0;
        #1 chk(rdata, PPMP_IFCFG_RESET);
        $display("test reset done");
        for (int s = 0; s < 4; s++) begin
            v = 8'($urandom) & 8'hfc | 8'(s);
            wreg(PPMP_ADDR_IFCFG, v);
            #1 chk(mm, v[1:0] == 2'h2);
            chk(sdoe, {3{v[2]}});
            chk(ickoe, v[7] & v[5]);
        end
        $display("test modes done");
        for (int i = 0; i < 2; i++) begin
            wreg(PPMP_ADDR_IFCFG, i ? 8'h16 : 8'he6);
            wreg(PPMP_ADDR_WAVE, 8'(i));
            a = 9'($urandom);
            wreg(PPMP_ADDR_ADRH, {7'h0, a[8]});
            wreg(PPMP_ADDR_ADRL, a[7:0]);
            wreg(PPMP_ADDR_PORTCFG, 8'h02);
            #1 chk({aoe, ao}, {9'h1ff, a});
            {wst, wctl, coe, wws} <= 17'($urandom);
            {wdat, fdi} <= $urandom;
            {inc, doe, slow} <= {2'h3, 1'(i)};
            ticks(1);
            inc <= 1'b0;
            ticks(20);
            #1 chk(ao, 9'(a + 9'h1));
            chk(sdo, wst);
            chk({ctl, ctloe}, {wctl, 6'h3f});
            chk(fdo, wdat);
            chk(fdoe, {{8{|wws}}, 8'hff});
            chk(hb, |wws);
            chk(rdo, ctl);
            if (i == 0) begin
                // Fast internal clock: one output rise per accumulator step unit
                n = 0;
                repeat (256) begin
                    p = icko;
                    @(posedge clk);
                    #1 n += int'(icko & ~p);
                end
                chk(16'(n), 16'(PPMP_STEP_FAST));
            end
            adr <= PPMP_ADDR_DATA;
            rd <= 1'b1;
            @(posedge clk);
            rd <= 1'b0;
            #1 chk(rdata, fdi[7:0]);
            wreg(PPMP_ADDR_CTLCFG, 8'h3f);
            ticks(2);
            #1 chk(ctloe, 6'(~wctl));
            wreg(PPMP_ADDR_CTLCFG, 8'h80);
            ticks(2);
            #1 chk(ctloe, {2'h0, coe});
            wreg(PPMP_ADDR_CTLCFG, 8'h00);
            wreg(PPMP_ADDR_PORTCFG, 8'h00);
            #1 chk(aoe, 9'h0);
            $display("test pins %0d done", i);
        end
        complete_run();
    end
endmodule
bind ppmp_pins ppmp_checker #(.READY_W(READY_W)) chk_u (.clk_i(clk_i), .resetn_i(resetn_i),
    .reg_addr_i(reg_addr_i), .reg_wdata_i(reg_wdata_i), .reg_wr_i(reg_wr_i),
    .ready_i(ready_i), .ready_o(ready_o), .interface_clock_tick_o(interface_clock_tick_o),
    .control_outputs_o(control_outputs_o), .control_outputs_oe_o(control_outputs_oe_o),
    .address_outputs_oe_o(address_outputs_oe_o), .interface_clock_oe_o(interface_clock_oe_o),
    .master_mode_o(master_mode_o));
